// File: logic/pief_pkg.sv
// shared constants and types for the port input mode and edge flag block
package pief_pkg;

  // ----------------------------------------------------------------
  // register word indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0] PIEF_IDX_EDGE_FLAGS = 8'hAD;
  localparam logic [7:0] PIEF_IDX_OUT_LATCH = 8'hB0;
  localparam logic [7:0] PIEF_IDX_INPUT_SEL = 8'hBD;
  localparam logic [7:0] PIEF_IDX_DRIVE_MODE = 8'hC0;
  localparam logic [7:0] PIEF_IDX_ROUTE = 8'hC1;
  localparam logic [7:0] PIEF_IDX_P1_LEVEL = 8'hC2;
  localparam logic [7:0] PIEF_IDX_P3_LEVEL = 8'hC3;
  localparam logic [7:0] PIEF_IDX_IRQ_STATUS = 8'hC4;
  localparam logic [7:0] PIEF_IDX_IRQ_MASK = 8'hC5;
  localparam int PIEF_IDX_LSB = 2;
  localparam int PIEF_IDX_MSB = 9;
  localparam int PIEF_HI_LSB = 10;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PIEF_RST_EDGE_FLAGS = 8'h00;
  localparam logic [7:0] PIEF_RST_OUT_LATCH = 8'hFF;
  localparam logic [7:0] PIEF_RST_INPUT_SEL = 8'hFF;
  localparam logic [7:0] PIEF_RST_DRIVE_MODE = 8'h00;
  localparam logic [7:0] PIEF_RST_ROUTE = 8'h00;
  localparam logic [1:0] PIEF_RST_IRQ = 2'h0;
  localparam logic [1:0] PIEF_IDLE_LEVEL = 2'h3;

  // ----------------------------------------------------------------
  // edge flag register layout: line 0 is pin 6, line 1 is pin 7
  // ----------------------------------------------------------------
  localparam int PIEF_LINES = 2;
  localparam int PIEF_FLAG_LSB = 6;
  localparam int PIEF_SEL_LSB = 2;
  localparam int PIEF_PIN_LSB = 6;
  localparam int PIEF_IRQ_LSB = 0;
  localparam logic [1:0] PIEF_HTRANS_NONSEQ = 2'h2;
  localparam logic PIEF_HRESP_OKAY = 1'b0;

  typedef enum logic [3:0] {
    PIEF_ST_IDLE = 4'h1,
    PIEF_ST_WRITE = 4'h2,
    PIEF_ST_RD_WAIT = 4'h4,
    PIEF_ST_RD_DONE = 4'h8
  } pief_state_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pief_pins_t;

  typedef struct packed {
    logic hit;
    logic [7:0] idx;
  } pief_addr_t;

endpackage

// File: logic/pief_port.sv
// port 1 input mode, port 3 latch and port 3 edge flags behind an AHB-Lite slave
//
// What this block does
// - input-select bit 0: analog mode, pull-up off, port 1 bit reads 0.
// - input-select bit 1: digital mode, port 1 bit reads the pin level.
// - port 3 latch reaches pins only where the crossbar leaves them unrouted; 0 low, 1 high.
// - latch bit 1 with drive-mode bit 0 leaves the pin undriven.
// - port 3 reads at index 0xB0 return the pin level regardless of crossbar setting; index 0xC3 returns the latch.
// - port 3 latch is 8 bits at index 0xB0, reset to all ones.
// - edges on port 3 pins 7 and 6 set pending flags bits 7 and 6.
// - pending flags stay set until software clears them; cleared reads 0.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module pief_port
  import pief_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] p1_pin_in,
  output logic [7:0] p1_pullup_en,
  output logic [7:0] p1_data,
  input wire logic [7:0] p3_pin_in,
  output logic [7:0] p3_pin_out,
  output logic [7:0] p3_pin_oe,
  input wire logic [7:0] p3_periph_out,
  input wire logic [7:0] p3_periph_oe,
  output logic irq
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  pief_state_t state;
  pief_state_t next_state;
  pief_addr_t aphase;
  pief_addr_t next_aphase;
  pief_pins_t p3_drive;
  logic [7:0] out_latch;
  logic [7:0] input_sel;
  logic [7:0] drive_mode;
  logic [7:0] route;
  logic [PIEF_LINES-1:0] pending;
  logic [PIEF_LINES-1:0] edge_sel;
  logic [PIEF_LINES-1:0] prev_level;
  logic [PIEF_LINES-1:0] edge_hit;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [7:0] rd_byte;
  logic take;
  logic wr_now;
  logic [7:0] wbyte;
  logic [7:0] local_oe;
  logic [7:0] edge_word;
  logic wr_edge;
  logic wr_latch;
  logic wr_input;
  logic wr_drive;
  logic wr_route;
  logic wr_status;
  logic wr_mask;

  // ----------------------------------------------------------------
  // bus address phase
  // ----------------------------------------------------------------
  // only NONSEQ starts a transfer; this slave never sees BUSY or SEQ
  assign take = hsel && hready && (htrans == PIEF_HTRANS_NONSEQ);
  assign wr_now = (state == PIEF_ST_WRITE) && aphase.hit;
  // hsize is not decoded: every access is taken as a whole word and only byte 0 is kept
  assign wbyte = hwdata[7:0];

  always_comb begin
    next_aphase.hit = (haddr[31:PIEF_HI_LSB] == '0);
    next_aphase.idx = haddr[PIEF_IDX_MSB:PIEF_IDX_LSB];
  end

  // reads take one wait cycle so a write in the cycle before is visible
  always_comb begin
    next_state = PIEF_ST_IDLE;
    case (state)
      PIEF_ST_RD_WAIT: begin
        next_state = PIEF_ST_RD_DONE;
      end
      PIEF_ST_IDLE, PIEF_ST_WRITE, PIEF_ST_RD_DONE: begin
        if (take) begin
          next_state = hwrite ? PIEF_ST_WRITE : PIEF_ST_RD_WAIT;
        end
      end
      default: begin
        next_state = PIEF_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= PIEF_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aphase <= '0;
    end else if (take) begin
      aphase <= next_aphase;
    end
  end

  // ----------------------------------------------------------------
  // data phase response
  // ----------------------------------------------------------------
  // every access completes, so an error response is never needed
  assign hreadyout = (state != PIEF_ST_RD_WAIT);
  assign hresp = PIEF_HRESP_OKAY;

  // ----------------------------------------------------------------
  // write strobes, valid in the data phase of a mapped write
  // ----------------------------------------------------------------
  // each strobe lasts one cycle and takes effect at the edge ending the data phase
  assign wr_edge = wr_now && (aphase.idx == PIEF_IDX_EDGE_FLAGS);
  assign wr_latch = wr_now && (aphase.idx == PIEF_IDX_OUT_LATCH);
  assign wr_input = wr_now && (aphase.idx == PIEF_IDX_INPUT_SEL);
  assign wr_drive = wr_now && (aphase.idx == PIEF_IDX_DRIVE_MODE);
  assign wr_route = wr_now && (aphase.idx == PIEF_IDX_ROUTE);
  assign wr_status = wr_now && (aphase.idx == PIEF_IDX_IRQ_STATUS);
  assign wr_mask = wr_now && (aphase.idx == PIEF_IDX_IRQ_MASK);

  // unused flag register bits stay at their reset zero on every read
  always_comb begin
    edge_word = PIEF_RST_EDGE_FLAGS;
    edge_word[PIEF_FLAG_LSB +: PIEF_LINES] = pending;
    edge_word[PIEF_SEL_LSB +: PIEF_LINES] = edge_sel;
  end

  // ----------------------------------------------------------------
  // read mux, captured into hrdata during the wait cycle
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = '0;
    if (aphase.hit) begin
      case (aphase.idx)
        PIEF_IDX_EDGE_FLAGS: begin
          rd_byte = edge_word;
        end
        PIEF_IDX_OUT_LATCH: begin
          rd_byte = p3_pin_in;
        end
        PIEF_IDX_INPUT_SEL: begin
          rd_byte = input_sel;
        end
        PIEF_IDX_DRIVE_MODE: begin
          rd_byte = drive_mode;
        end
        PIEF_IDX_ROUTE: begin
          rd_byte = route;
        end
        PIEF_IDX_P1_LEVEL: begin
          rd_byte = p1_data;
        end
        PIEF_IDX_P3_LEVEL: begin
          rd_byte = out_latch;
        end
        PIEF_IDX_IRQ_STATUS: begin
          rd_byte[PIEF_IRQ_LSB +: PIEF_LINES] = irq_status;
        end
        PIEF_IDX_IRQ_MASK: begin
          rd_byte[PIEF_IRQ_LSB +: PIEF_LINES] = irq_mask;
        end
        default: begin
          rd_byte = '0;
        end
      endcase
    end
  end

  // upper bytes stay zero: every register here is one byte wide
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (state == PIEF_ST_RD_WAIT) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // software sees the latch as one byte; single-bit access is left to the core
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_latch <= PIEF_RST_OUT_LATCH;
    end else if (wr_latch) begin
      out_latch <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_sel <= PIEF_RST_INPUT_SEL;
    end else if (wr_input) begin
      input_sel <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_mode <= PIEF_RST_DRIVE_MODE;
    end else if (wr_drive) begin
      drive_mode <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      route <= PIEF_RST_ROUTE;
    end else if (wr_route) begin
      route <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_sel <= PIEF_RST_EDGE_FLAGS[PIEF_SEL_LSB +: PIEF_LINES];
    end else if (wr_edge) begin
      edge_sel <= wbyte[PIEF_SEL_LSB +: PIEF_LINES];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= PIEF_RST_IRQ;
    end else if (wr_mask) begin
      irq_mask <= wbyte[PIEF_IRQ_LSB +: PIEF_LINES];
    end
  end

  // ----------------------------------------------------------------
  // port 1 input mode
  // ----------------------------------------------------------------
  // analog pins keep the digital path gated so a floating level never shows
  assign p1_pullup_en = input_sel;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p1_data <= '0;
    end else begin
      p1_data <= p1_pin_in & input_sel;
    end
  end

  // ----------------------------------------------------------------
  // port 3 pin drive
  // ----------------------------------------------------------------
  // open drain: a latched one only drives when its drive-mode bit is set
  assign local_oe = ~out_latch | drive_mode;
  // a routed bit hands the pin to the peripheral; the latch still holds its value
  always_comb begin
    p3_drive.out = (route & p3_periph_out) | (~route & out_latch);
    p3_drive.oe = (route & p3_periph_oe) | (~route & local_oe);
  end

  // registered so the pads never glitch while route and latch change together
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p3_pin_out <= PIEF_RST_OUT_LATCH;
      p3_pin_oe <= PIEF_RST_DRIVE_MODE;
    end else begin
      p3_pin_out <= p3_drive.out;
      p3_pin_oe <= p3_drive.oe;
    end
  end

  // ----------------------------------------------------------------
  // edge detection and pending flags
  // ----------------------------------------------------------------
  // reset to the pulled-up idle level so release does not fake a rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_level <= PIEF_IDLE_LEVEL;
    end else begin
      prev_level <= p3_pin_in[PIEF_PIN_LSB +: PIEF_LINES];
    end
  end

  genvar g;
  generate
    for (g = 0; g < PIEF_LINES; g++) begin : g_line
      logic cur;
      logic rise;
      logic fall;
      logic clr;
      logic ack;
      // each line compares the pin with the level it had at the previous edge
      assign cur = p3_pin_in[PIEF_PIN_LSB + g];
      assign rise = cur && !prev_level[g];
      assign fall = !cur && prev_level[g];
      assign edge_hit[g] = edge_sel[g] ? rise : fall;
      // writing a one leaves the flag alone, only a zero clears it
      assign clr = wr_edge && !wbyte[PIEF_FLAG_LSB + g];
      assign ack = wr_status && wbyte[PIEF_IRQ_LSB + g];

      // a new edge in the clearing cycle wins so it is never lost
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pending[g] <= PIEF_RST_EDGE_FLAGS[PIEF_FLAG_LSB + g];
        end else if (edge_hit[g]) begin
          pending[g] <= 1'b1;
        end else if (clr) begin
          pending[g] <= 1'b0;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          irq_status[g] <= PIEF_RST_IRQ[g];
        end else if (edge_hit[g]) begin
          irq_status[g] <= 1'b1;
        end else if (ack) begin
          irq_status[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  // level output: it drops only once software has acknowledged every unmasked cause
  assign irq = |(irq_status & irq_mask);

endmodule

// File: sim/pief_port_sva.sv
// assertion checker for the port block bus timing and pin reads
`timescale 1ns/10ps
module pief_port_sva
  import pief_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] p1_pin_in,
  input wire logic [7:0] p1_pullup_en,
  input wire logic [7:0] p1_data,
  input wire logic [7:0] p3_pin_in,
  input wire logic [7:0] p3_pin_out,
  input wire logic [7:0] p3_pin_oe
);
  logic req;
  assign req = hsel && hready && htrans == PIEF_HTRANS_NONSEQ;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_p1_read;
    $past(hresetn) |-> p1_data == $past(p1_pin_in & p1_pullup_en);
  endproperty
  a_p1_read: assert property (p_p1_read) else $error("port 1 read wrong");
  property p_okay;
    hresp == PIEF_HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_rd_wait;
    req && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_nowait;
    req && hwrite |=> hreadyout;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_hi_zero;
    hreadyout |-> hrdata[31:8] == 24'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  property p_unused;
    req && !hwrite && haddr == 32'h2B4 |=> ##1 hrdata[5:4] == 2'h0 && hrdata[1:0] == 2'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused flag bits set");
  property p_p3_read;
    req && !hwrite && haddr == 32'h2C0 |=> ##1 hrdata[7:0] == $past(p3_pin_in);
  endproperty
  a_p3_read: assert property (p_p3_read) else $error("port 3 read not pin");
  property p_latch_rst;
    $rose(hresetn) |-> p3_pin_out == 8'hFF && p3_pin_oe == 8'h00;
  endproperty
  a_latch_rst: assert property (p_latch_rst) else $error("latch reset wrong");
endmodule
bind pief_port pief_port_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .p1_pin_in, .p1_pullup_en, .p1_data, .p3_pin_in,
  .p3_pin_out, .p3_pin_oe);

// File: sim/pief_pin_model.sv
// pin side: pulled-up port 3 wires, open-drain outside drivers, port 1 levels
`timescale 1ns/10ps
module pief_pin_model (
  input wire logic [7:0] p3_pin_out,
  input wire logic [7:0] p3_pin_oe,
  input wire logic [7:0] ext_low,
  input wire logic [7:0] p1_level,
  output logic [7:0] p3_pin_in,
  output logic [7:0] p1_pin_in
);
  // undriven pins float up, so any driver can only win by pulling low
  assign p3_pin_in = ~(p3_pin_oe & ~p3_pin_out) & ~ext_low;
  assign p1_pin_in = p1_level;
endmodule

// File: sim/tb_top.sv
// register-level testbench for the port block
`timescale 1ns/10ps
module tb_top;
  import pief_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [7:0] p1_pin_in, p1_pullup_en, p1_data, p3_pin_in, p3_pin_out, p3_pin_oe;
  logic [7:0] periph_out, periph_oe, ext_low, p1_level, cfg;
  int n_fail, compares;
  pief_port u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .p1_pin_in, .p1_pullup_en, .p1_data,
    .p3_pin_in, .p3_pin_out, .p3_pin_oe, .p3_periph_out(periph_out),
    .p3_periph_oe(periph_oe), .irq);
  pief_pin_model u_pins (.p3_pin_out, .p3_pin_oe, .ext_low, .p1_level, .p3_pin_in,
    .p1_pin_in);
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ready is read half a cycle early; it only moves just after a rising edge
  task automatic wait_rdy;
    logic r;
    int n;
    n = 0;
    r = 1'b0;
    while (!r) begin
      @(negedge hclk);
      r = hreadyout;
      q = hrdata;
      @(posedge hclk);
      n++;
      if (n > 50) begin
        n_fail++;
        give_verdict();
      end
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= PIEF_HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q[7:0], exp);
  endtask
  initial begin
    n_fail = 0;
    compares = 0;
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    periph_out = 8'h00;
    periph_oe = 8'h00;
    ext_low = 8'h00;
    p1_level = 8'hA5;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h2B4, 8'h00);
    rd(32'h30C, 8'hFF);
    rd(32'h2C0, 8'hFF);
    @(negedge hclk);
    chk(p3_pin_oe, 8'h00);
    xfer(1'b1, 32'h2F4, 32'h0F);
    @(negedge hclk);
    chk(p1_pullup_en, 8'h0F);
    rd(32'h308, 8'h05);
    xfer(1'b1, 32'h2C0, 32'h5A);
    xfer(1'b1, 32'h300, 32'h0F);
    ext_low <= 8'h02;
    repeat (2) @(negedge hclk);
    chk(p3_pin_oe, 8'hAF);
    chk(p3_pin_out, 8'h5A);
    rd(32'h2C0, 8'h58);
    rd(32'h30C, 8'h5A);
    periph_oe <= 8'h40;
    xfer(1'b1, 32'h304, 32'h40);
    repeat (2) @(negedge hclk);
    chk(p3_pin_oe, 8'hEF);
    chk(p3_pin_out, 8'h1A);
    rd(32'h2C0, 8'h18);
    xfer(1'b1, 32'h304, 32'h0);
    xfer(1'b1, 32'h2C0, 32'hFF);
    xfer(1'b1, 32'h300, 32'h0);
    ext_low <= 8'h00;
    for (int k = 0; k < 2; k++) begin
      cfg = k ? 8'h0C : 8'h00;
      xfer(1'b1, 32'h2B4, {24'h0, cfg});
      rd(32'h2B4, cfg);
      ext_low <= 8'hC0;
      rd(32'h2B4, cfg | (k ? 8'h00 : 8'hC0));
      ext_low <= 8'h00;
      rd(32'h2B4, cfg | 8'hC0);
      xfer(1'b1, 32'h2B4, {24'h0, cfg | 8'hC0});
      rd(32'h2B4, cfg | 8'hC0);
    end
    xfer(1'b1, 32'h2B4, 32'h37);
    rd(32'h2B4, 8'h04);
    xfer(1'b1, 32'h4B4, 32'hFF);
    rd(32'h4B4, 8'h00);
    rd(32'h2B4, 8'h04);
    @(negedge hclk);
    chk({7'h0, irq}, 8'h00);
    rd(32'h310, 8'h03);
    xfer(1'b1, 32'h314, 32'h3);
    @(negedge hclk);
    chk({7'h0, irq}, 8'h01);
    xfer(1'b1, 32'h310, 32'h3);
    @(negedge hclk);
    chk({7'h0, irq}, 8'h00);
    rd(32'h310, 8'h00);
    give_verdict();
  end
endmodule
